// File: xdata_mapped_register_window_tb_top.sv
// testbench for the external-data mapped register window
// assumes the cpu model drives all bus strobes
`timescale 1ns/10ps
module xdata_mapped_register_window_tb_top;
  import xmr_pkg::*;
  logic i_mclk, i_rst_b, xwr, xrd, xsel;
  logic [15:0] xaddr;
  logic [7:0] xwdata, xrdata, trim, pmax, xo, ptst;
  logic [8:0] cap;
  logic [31:0] freq;
  logic [127:0] nvm;
  int miscompares = 0;
  int total_checks = 0;
  logic [15:0] bregs[4] = '{OFS_LPOSC_TRIM, OFS_PA_MAX_DRIVE, OFS_XO_CTRL, OFS_PORT_TEST};
  logic [15:0] rsvd[9] = '{16'h4003, 16'h4007, 16'h400E, 16'h4011, 16'h4013, 16'h4015, 16'h4018, 16'h403F, 16'h0002};
  xmr_window i_xmr_window (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_xaddr(xaddr), .i_xwr(xwr), .i_xrd(xrd),
    .i_xwdata(xwdata), .o_xrdata(xrdata), .o_xsel(xsel), .i_freq_counter_result(freq), .i_nvm_read_bytes(nvm),
    .o_low_power_osc_trim(trim), .o_pa_tuning_capacitor(cap), .o_pa_max_drive(pmax),
    .o_crystal_osc_control(xo), .o_port_test_control(ptst));
  xmr_cpu_model i_xmr_cpu_model (.i_mclk(i_mclk), .i_xrdata(xrdata), .o_xaddr(xaddr), .o_xwr(xwr),
    .o_xrd(xrd), .o_xwdata(xwdata));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_xmr_cpu_model.rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  // select only for strobed bank cycles
  always @(posedge i_mclk)
    if (i_rst_b && (xrd || xwr))
      chk({15'h0000, xsel}, {15'h0000, (xaddr >= BANK_BASE) && (xaddr <= BANK_LAST)});
  // watchdog: whole run needs well under 1000 cycles
  initial begin
    #200000;
    miscompares++;
    results();
  end
  initial begin
    i_rst_b = 1'b0;
    freq = 32'h12345678;
    for (int k = 0; k < 16; k++)
      nvm[8*k +: 8] = 8'hA0 + 8'(k);
    repeat (20) @(posedge i_mclk);
    #1;
    i_rst_b = 1'b1;
    foreach (bregs[k]) rchk(bregs[k], 8'h00);
    foreach (bregs[k]) i_xmr_cpu_model.wr(bregs[k], 8'hC0 + 8'(k));
    // alias below the bank must not land on a register
    foreach (rsvd[k]) i_xmr_cpu_model.wr(rsvd[k], 8'hFF);
    foreach (rsvd[k]) if (k < 8) rchk(rsvd[k], 8'h00);
    foreach (bregs[k]) rchk(bregs[k], 8'hC0 + 8'(k));
    chk({8'h00, trim}, 16'h00C0);
    chk({8'h00, pmax}, 16'h00C1);
    chk({8'h00, xo}, 16'h00C2);
    chk({8'h00, ptst}, 16'h00C3);
    i_xmr_cpu_model.wr(OFS_PA_CAP, 8'hFF);
    i_xmr_cpu_model.wr(OFS_PA_CAP + 16'h0001, 8'h3C);
    rchk(OFS_PA_CAP, 8'h01);
    rchk(OFS_PA_CAP + 16'h0001, 8'h3C);
    chk({7'h00, cap}, 16'h013C);
    for (int k = 0; k < 4; k++)
      rchk(OFS_FREQ_COUNT + 16'(k), freq[31-8*k -: 8]);
    // read-only: write must not disturb the live count
    i_xmr_cpu_model.wr(OFS_FREQ_COUNT, 8'h00);
    rchk(OFS_FREQ_COUNT, 8'h12);
    freq = 32'h0056789A;
    rchk(OFS_FREQ_COUNT, 8'h00);
    rchk(OFS_FREQ_COUNT + 16'h0003, 8'h9A);
    for (int k = 0; k < 16; k++)
      rchk(OFS_NVM_BYTES + 16'(k), 8'hA0 + 8'(k));
    // second reset mid-run must clear written registers
    i_rst_b = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    i_rst_b = 1'b1;
    foreach (bregs[k]) rchk(bregs[k], 8'h00);
    rchk(OFS_PA_CAP + 16'h0001, 8'h00);
    results();
  end
endmodule // xdata_mapped_register_window_tb_top

// File: xmr_byte_lane.sv
// byte-lane selector: picks one byte of a big-endian word
// assumes lane index counted from the lowest address
`timescale 1ns/10ps
module xmr_byte_lane #(
  parameter int unsigned BYTES = 4
) (
  // word and lane
  input wire logic [8*BYTES-1:0] i_word,
  input wire logic [$clog2(BYTES)-1:0] i_lane,
  // selected byte
  output logic [7:0] o_byte
);
  assign o_byte = i_word[8*(BYTES-1-i_lane) +: 8];
endmodule // xmr_byte_lane

// File: xmr_cpu_model.sv
// cpu-side model: single-byte movx read and write cycles
// assumes the window samples strobes on the rising edge of i_mclk
`timescale 1ns/10ps
module xmr_cpu_model (
  // clock and read data
  input wire logic i_mclk,
  input wire logic [7:0] i_xrdata,
  // external data strobes
  output logic [15:0] o_xaddr,
  output logic o_xwr,
  output logic o_xrd,
  output logic [7:0] o_xwdata
);
  initial begin
    o_xaddr = 16'hFFFF;
    o_xwr = 1'b0;
    o_xrd = 1'b0;
    o_xwdata = 8'hFF;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_xaddr = a;
    o_xwdata = d;
    o_xwr = 1'b1;
    @(posedge i_mclk);
    #1;
    o_xwr = 1'b0;
    // released bus shows inverse, never a stale value
    o_xaddr = ~a;
    o_xwdata = ~d;
  endtask
  // movx read cycle, data next edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_xaddr = a;
    o_xrd = 1'b1;
    @(posedge i_mclk);
    #1;
    o_xrd = 1'b0;
    o_xaddr = ~a;
    d = i_xrdata;
  endtask
endmodule // xmr_cpu_model

// File: xmr_pkg.sv
// package for the external-data mapped register window
// assumes a byte-wide external data bus from the cpu core
package xmr_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] BANK_BASE = 16'h4000;
  localparam logic [15:0] BANK_LAST = 16'h404F;
  localparam logic [15:0] OFS_LPOSC_TRIM = 16'h4002;
  localparam logic [15:0] OFS_FREQ_COUNT = 16'h4008;
  localparam logic [15:0] OFS_PA_CAP = 16'h400C;
  localparam logic [15:0] OFS_PA_MAX_DRIVE = 16'h4012;
  localparam logic [15:0] OFS_XO_CTRL = 16'h4016;
  localparam logic [15:0] OFS_PORT_TEST = 16'h4017;
  localparam logic [15:0] OFS_NVM_BYTES = 16'h4040;
  localparam int unsigned NVM_BYTES = 16;
  localparam int unsigned PA_CAP_W = 9;
  localparam int unsigned FREQ_COUNT_W = 32;
  localparam logic [7:0] RST_LPOSC_TRIM = 8'h00;
  localparam logic [8:0] RST_PA_CAP = 9'h000;
  localparam logic [7:0] RST_PA_MAX_DRIVE = 8'h00;
  localparam logic [7:0] RST_XO_CTRL = 8'h00;
  localparam logic [7:0] RST_PORT_TEST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  typedef enum logic [1:0] {
    XMR_IDLE = 2'b00,
    XMR_READ = 2'b01
  } xmr_cycle_type;
endpackage : xmr_pkg

// File: xmr_window.sv
// external-data mapped register bank: decode, byte lanes, storage
// assumes the cpu issues single-cycle movx strobes on i_mclk
//
// Contract
// - bank decoded only from external data space cycles
// - registers one, two or four bytes, aligned to own size
// - multi-byte non-array registers big-endian, msb at lowest address
// - 23-bit style register gets four bytes, zero top byte; the 32-bit freq counter top byte is passed through, not zeroed
// - array index zero at lowest address, rising with address
// - narrow fields start at bit zero, toward least significant byte
// - bits above a field read zero, writes ignored
// - pa tuning capacitor is 9 bits, bits 15:9 read zero
`timescale 1ns/10ps
module xmr_window (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // external data bus strobes from cpu core
  input wire logic [xmr_pkg::ADDR_W-1:0] i_xaddr,
  input wire logic i_xwr,
  input wire logic i_xrd,
  input wire logic [7:0] i_xwdata,
  output logic [7:0] o_xrdata,
  output logic o_xsel,
  // peripheral side
  input wire logic [xmr_pkg::FREQ_COUNT_W-1:0] i_freq_counter_result,
  input wire logic [8*xmr_pkg::NVM_BYTES-1:0] i_nvm_read_bytes,
  output logic [7:0] o_low_power_osc_trim,
  output logic [xmr_pkg::PA_CAP_W-1:0] o_pa_tuning_capacitor,
  output logic [7:0] o_pa_max_drive,
  output logic [7:0] o_crystal_osc_control,
  output logic [7:0] o_port_test_control
);
  import xmr_pkg::*;

  logic [7:0] lposc_q;
  logic [PA_CAP_W-1:0] pacap_q;
  logic [7:0] pamax_q;
  logic [7:0] xo_q;
  logic [7:0] port_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] count_byte;
  logic [7:0] pacap_byte;
  logic [15:0] pacap_word;

  // only movx cycles in bank range
  wire in_bank = (i_xaddr >= BANK_BASE) && (i_xaddr <= BANK_LAST);
  wire wr_hit = i_xwr && in_bank;
  wire rd_hit = i_xrd && in_bank;
  wire hit_lposc = (i_xaddr == OFS_LPOSC_TRIM);
  wire hit_count = (i_xaddr[15:2] == OFS_FREQ_COUNT[15:2]);
  wire hit_pacap = (i_xaddr[15:1] == OFS_PA_CAP[15:1]);
  wire hit_pamax = (i_xaddr == OFS_PA_MAX_DRIVE);
  wire hit_xo = (i_xaddr == OFS_XO_CTRL);
  wire hit_port = (i_xaddr == OFS_PORT_TEST);
  wire hit_nvm = (i_xaddr[15:4] == OFS_NVM_BYTES[15:4]);
  assign pacap_word = {{(16 - PA_CAP_W){1'b0}}, pacap_q};
  wire [7:0] nvm_byte = i_nvm_read_bytes[8*i_xaddr[3:0] +: 8];

  // four-byte slot, lsb at base plus three
  xmr_byte_lane #(.BYTES(4)) u_count_lane (
    .i_word(i_freq_counter_result),
    .i_lane(i_xaddr[1:0]),
    .o_byte(count_byte)
  );
  xmr_byte_lane #(.BYTES(2)) u_pacap_lane (
    .i_word(pacap_word),
    .i_lane(i_xaddr[0]),
    .o_byte(pacap_byte)
  );

  always_comb begin
    rdata_d = ZERO_BYTE;
    if (hit_lposc) rdata_d = lposc_q;
    else if (hit_count) rdata_d = count_byte;
    else if (hit_pacap) rdata_d = pacap_byte;
    else if (hit_pamax) rdata_d = pamax_q;
    else if (hit_xo) rdata_d = xo_q;
    else if (hit_port) rdata_d = port_q;
    else if (hit_nvm) rdata_d = nvm_byte;
  end

  // read data held until next bank read
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= ZERO_BYTE;
    end else if (rd_hit) begin
      rdata_q <= rdata_d;
    end
  end

  // fields at bit zero of lsb byte
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lposc_q <= RST_LPOSC_TRIM;
      pacap_q <= RST_PA_CAP;
      pamax_q <= RST_PA_MAX_DRIVE;
      xo_q <= RST_XO_CTRL;
      port_q <= RST_PORT_TEST;
    end else if (wr_hit) begin
      if (hit_lposc) lposc_q <= i_xwdata;
      // msb byte keeps only bit 8
      if (hit_pacap && !i_xaddr[0]) pacap_q[8] <= i_xwdata[0];
      if (hit_pacap && i_xaddr[0]) pacap_q[7:0] <= i_xwdata;
      if (hit_pamax) pamax_q <= i_xwdata;
      if (hit_xo) xo_q <= i_xwdata;
      if (hit_port) port_q <= i_xwdata;
    end
  end

  assign o_xrdata = rdata_q;
  assign o_xsel = in_bank && (i_xrd || i_xwr);
  assign o_low_power_osc_trim = lposc_q;
  assign o_pa_tuning_capacitor = pacap_q;
  assign o_pa_max_drive = pamax_q;
  assign o_crystal_osc_control = xo_q;
  assign o_port_test_control = port_q;

  // lowest address gives msb of counter
  property p_count_msb;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xrd && i_xaddr == OFS_FREQ_COUNT) |=> (o_xrdata == $past(i_freq_counter_result[31:24]));
  endproperty
  a_count_msb: assert property (p_count_msb) else $error("counter msb lane wrong");
  property p_count_lsb;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xrd && i_xaddr == 16'h400B) |=> (o_xrdata == $past(i_freq_counter_result[7:0]));
  endproperty
  a_count_lsb: assert property (p_count_lsb) else $error("counter lsb lane wrong");
  // top byte of cap reads 0 or 1
  property p_pacap_top;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xrd && i_xaddr == OFS_PA_CAP) |=> (o_xrdata[7:1] == 7'h00);
  endproperty
  a_pacap_top: assert property (p_pacap_top) else $error("cap upper bits not zero");
  property p_reserved_zero;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xrd && i_xaddr == 16'h4003) |=> (o_xrdata == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read nonzero");
  property p_nvm_index;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xrd && i_xaddr == OFS_NVM_BYTES) |=> (o_xrdata == $past(i_nvm_read_bytes[7:0]));
  endproperty
  a_nvm_index: assert property (p_nvm_index) else $error("array index zero wrong");
  property p_trim_write;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xwr && i_xaddr == OFS_LPOSC_TRIM) |=> (o_low_power_osc_trim == $past(i_xwdata));
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");
  // cap msb write keeps bit 8 only
  property p_pacap_write;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xwr && i_xaddr == OFS_PA_CAP) |=> (o_pa_tuning_capacitor[8] == $past(i_xwdata[0]))
      && $stable(o_pa_tuning_capacitor[7:0]);
  endproperty
  a_pacap_write: assert property (p_pacap_write) else $error("cap msb write wrong");
  property p_no_cycle;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (!i_xrd && !i_xwr) |=> $stable(o_xrdata) && $stable(o_crystal_osc_control);
  endproperty
  a_no_cycle: assert property (p_no_cycle) else $error("change without bus cycle");
  // word read at odd address picks lsb
  property p_pacap_lsb;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xrd && i_xaddr == 16'h400D) |=> (o_xrdata == $past(o_pa_tuning_capacitor[7:0]));
  endproperty
  a_pacap_lsb: assert property (p_pacap_lsb) else $error("cap lsb lane wrong");
  property p_count_mid;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xrd && i_xaddr == OFS_FREQ_COUNT + 16'h0001) |=> (o_xrdata == $past(i_freq_counter_result[23:16]));
  endproperty
  a_count_mid: assert property (p_count_mid) else $error("counter second lane wrong");
  property p_nvm_last;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xrd && i_xaddr == OFS_NVM_BYTES + 16'h000F) |=> (o_xrdata == $past(i_nvm_read_bytes[127:120]));
  endproperty
  a_nvm_last: assert property (p_nvm_last) else $error("array last element wrong");
  property p_reserved_write;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xwr && i_xaddr == OFS_LPOSC_TRIM + 16'h0001) |=> $stable(o_low_power_osc_trim)
      && $stable(o_pa_tuning_capacitor) && $stable(o_pa_max_drive)
      && $stable(o_crystal_osc_control) && $stable(o_port_test_control);
  endproperty
  a_reserved_write: assert property (p_reserved_write) else $error("reserved write changed a register");
  property p_outside_write;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xwr && i_xaddr < BANK_BASE) |=> $stable(o_low_power_osc_trim)
      && $stable(o_pa_tuning_capacitor) && $stable(o_pa_max_drive)
      && $stable(o_crystal_osc_control) && $stable(o_port_test_control);
  endproperty
  a_outside_write: assert property (p_outside_write) else $error("write outside bank changed a register");
  // cap lsb write keeps bit 8
  property p_pacap_lo_write;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xwr && i_xaddr == OFS_PA_CAP + 16'h0001) |=> (o_pa_tuning_capacitor[7:0] == $past(i_xwdata))
      && $stable(o_pa_tuning_capacitor[8]);
  endproperty
  a_pacap_lo_write: assert property (p_pacap_lo_write) else $error("cap lsb write wrong");
  property p_pamax_write;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xwr && i_xaddr == OFS_PA_MAX_DRIVE) |=> (o_pa_max_drive == $past(i_xwdata));
  endproperty
  a_pamax_write: assert property (p_pamax_write) else $error("drive write lost");
  property p_xo_write;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xwr && i_xaddr == OFS_XO_CTRL) |=> (o_crystal_osc_control == $past(i_xwdata));
  endproperty
  a_xo_write: assert property (p_xo_write) else $error("oscillator control write lost");
  property p_port_write;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_xwr && i_xaddr == OFS_PORT_TEST) |=> (o_port_test_control == $past(i_xwdata));
  endproperty
  a_port_write: assert property (p_port_write) else $error("port test write lost");
endmodule // xmr_window
